// file: cmb_pkg.sv
/*
 * Shared constants for the CAN message buffer store: word indices, field
 * positions, implemented-bit masks and the reset value of the memory read data.
 * Assumes a 16-bit buffer word and eight words per message buffer.
 */
package cmb_pkg;
    // ------------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------------
    localparam int CMB_WORD_W = 16;
    localparam int CMB_WORDS = 8;
    localparam int CMB_WSEL_W = 3;
    localparam int CMB_DATA_BYTES = 8;
    localparam logic [3:0] CMB_MAX_BYTES = 4'h8;

    // Word indices inside one buffer.
    localparam logic [2:0] CMB_W_STD_ID = 3'h0;
    localparam logic [2:0] CMB_W_EXT_ID_HIGH = 3'h1;
    localparam logic [2:0] CMB_W_EXT_ID_LOW_LEN = 3'h2;
    localparam logic [2:0] CMB_W_DATA_FIRST = 3'h3;
    localparam logic [2:0] CMB_W_DATA_LAST = 3'h6;
    localparam logic [2:0] CMB_W_FILTER_HIT = 3'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMB_SID_W = 11;
    localparam int CMB_SID_LSB = 2;
    localparam int CMB_SRR_BIT = 1;
    localparam int CMB_IDE_BIT = 0;
    localparam int CMB_EID_W = 18;
    localparam int CMB_EID_HIGH_W = 12;
    localparam int CMB_EID_HIGH_LSB = 0;
    localparam int CMB_EID_LOW_W = 6;
    localparam int CMB_EID_LOW_LSB = 10;
    localparam int CMB_RTR_BIT = 9;
    localparam int CMB_RSV_HIGH_BIT = 8;
    localparam int CMB_RSV_LOW_BIT = 4;
    localparam int CMB_DLC_W = 4;
    localparam int CMB_DLC_LSB = 0;
    localparam int CMB_FHIT_W = 5;
    localparam int CMB_FHIT_LSB = 8;
    localparam int CMB_BYTE_W = 8;

    // ------------------------------------------------------------------
    // Implemented bits per word; the rest always read as zero
    // ------------------------------------------------------------------
    localparam logic [15:0] CMB_MASK_STD_ID = 16'h1fff;
    localparam logic [15:0] CMB_MASK_EXT_HIGH = 16'h0fff;
    localparam logic [15:0] CMB_MASK_EXT_LOW = 16'hff1f;
    localparam logic [15:0] CMB_MASK_DATA = 16'hffff;
    localparam logic [15:0] CMB_MASK_FHIT = 16'h1f00;

    // Reset value of the memory read data output.
    localparam logic [15:0] CMB_RDATA_RST = 16'h0000;
endpackage

// file: cmb_rx_packer.sv
/*
 * Packs one received CAN message into the eight words of a message buffer,
 * with a write enable per byte lane. Purely combinational; the caller
 * owns the storage and applies the enables.
 */
`timescale 1ns/1ps
module cmb_rx_packer
    import cmb_pkg::*;
(
    // Received message fields
    input wire logic [CMB_SID_W-1:0] standard_identifier_bits,
    input wire logic srr,
    input wire logic ide,
    input wire logic [CMB_EID_W-1:0] extended_identifier_bits,
    input wire logic rtr,
    input wire logic [CMB_DLC_W-1:0] dlc,
    input wire logic [CMB_DATA_BYTES*CMB_BYTE_W-1:0] data,
    input wire logic [CMB_FHIT_W-1:0] filter_num,
    // Kind of the target buffer
    input wire logic target_is_tx,
    // Packed image and byte-lane enables
    output logic [CMB_WORDS*CMB_WORD_W-1:0] words,
    output logic [CMB_WORDS*2-1:0] byte_we
);
    logic [3:0] nbytes;
    logic [7:0] data_be;

    assign nbytes = (dlc > CMB_MAX_BYTES) ? CMB_MAX_BYTES : dlc;

    always_comb begin
        words = '0;
        byte_we = '0;
        data_be = '0;
        words[CMB_SID_LSB +: CMB_SID_W] = standard_identifier_bits;
        words[CMB_SRR_BIT] = srr;
        words[CMB_IDE_BIT] = ide;
        words[CMB_WORD_W + CMB_EID_HIGH_LSB +: CMB_EID_HIGH_W] =
            extended_identifier_bits[CMB_EID_W-1 -: CMB_EID_HIGH_W];
        words[2*CMB_WORD_W + CMB_EID_LOW_LSB +: CMB_EID_LOW_W] =
            extended_identifier_bits[CMB_EID_LOW_W-1:0];
        words[2*CMB_WORD_W + CMB_RTR_BIT] = rtr;
        // Reserved bits are stored as zero, the same as software must write.
        words[2*CMB_WORD_W + CMB_RSV_HIGH_BIT] = 1'b0;
        words[2*CMB_WORD_W + CMB_RSV_LOW_BIT] = 1'b0;
        words[2*CMB_WORD_W + CMB_DLC_LSB +: CMB_DLC_W] = dlc;
        for (int b = 0; b < CMB_DATA_BYTES; b++) begin
            // Byte b goes to word 3 + b/2, low lane for even b.
            words[(3*CMB_WORD_W) + b*CMB_BYTE_W +: CMB_BYTE_W] =
                data[b*CMB_BYTE_W +: CMB_BYTE_W];
            data_be[b] = (4'(b) < nbytes);
        end
        words[7*CMB_WORD_W + CMB_FHIT_LSB +: CMB_FHIT_W] =
            filter_num;
        byte_we[5:0] = 6'h3f;
        byte_we[13:6] = data_be;
        // Transmit buffers keep their filter-hit word untouched.
        byte_we[15:14] = target_is_tx ? 2'b00 : 2'b11;
    end
endmodule

// file: cmb_msg_buffer.sv
/*
 * CAN message buffer store. Holds NUM_BUF buffers of eight 16-bit words in
 * the layout shared by software and the protocol engine. Software and DMA
 * reach the words through a plain memory port; the protocol engine stores
 * received messages and fetches messages to send, unpacked into fields.
 * Assumes every port is driven from logic on clk; nothing is asynchronous.
 */
// Notes on behaviour
// - Extended id bits 17-6 go to word 1 bits 11-0, bits 5-0 to word 2 15-10.
// - Word 2 bit 9 set means remote request, clear means data message.
// - Data length code sits in word 2 bits 3-0.
// - Data bytes pack two per word, words 3-6, even byte in low half.
// - A reception writes the matching filter number into word 7 bits 12-8.
// - No filter number is written into a transmit buffer.
// - Unimplemented bits of words 1, 2 and 7 always read zero.
// - Word 0 holds standard id 12-2, substitute request 1, extended flag 0.
`timescale 1ns/1ps
module cmb_msg_buffer
    import cmb_pkg::*;
#(
    parameter int NUM_BUF = 4
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Memory port used by software and DMA
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [$clog2(NUM_BUF)-1:0] mem_buf,
    input wire logic [CMB_WSEL_W-1:0] mem_word,
    input wire logic [CMB_WORD_W-1:0] mem_wdata,
    output logic [CMB_WORD_W-1:0] mem_rdata,
    output logic mem_rvalid,
    // Buffer direction, one bit per buffer, set for transmit buffers
    input wire logic [NUM_BUF-1:0] buf_is_tx,
    // Receive store from the protocol engine
    input wire logic rx_store,
    input wire logic [$clog2(NUM_BUF)-1:0] rx_buf,
    input wire logic [CMB_SID_W-1:0] rx_sid,
    input wire logic rx_srr,
    input wire logic rx_ide,
    input wire logic [CMB_EID_W-1:0] rx_eid,
    input wire logic rx_rtr,
    input wire logic [CMB_DLC_W-1:0] rx_dlc,
    input wire logic [CMB_DATA_BYTES*CMB_BYTE_W-1:0] rx_data,
    input wire logic [CMB_FHIT_W-1:0] rx_filter,
    output logic rx_done,
    // Transmit fetch for the protocol engine
    input wire logic tx_fetch,
    input wire logic [$clog2(NUM_BUF)-1:0] tx_buf,
    output logic tx_valid,
    output logic [CMB_SID_W-1:0] tx_sid,
    output logic tx_srr,
    output logic tx_ide,
    output logic [CMB_EID_W-1:0] tx_eid,
    output logic tx_rtr,
    output logic [CMB_DLC_W-1:0] tx_dlc,
    output logic [CMB_DATA_BYTES*CMB_BYTE_W-1:0] tx_data,
    output logic [CMB_DATA_BYTES-1:0] tx_byte_en
);
    import cmb_pkg::*;

    localparam int BW = $clog2(NUM_BUF);
    localparam int DEPTH = NUM_BUF * CMB_WORDS;
    localparam int IW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Implemented bits of a buffer word; everything else is held at zero.
    function automatic logic [CMB_WORD_W-1:0] word_mask(
        input logic [CMB_WSEL_W-1:0] w
    );
        logic [CMB_WORD_W-1:0] m;
        m = CMB_MASK_DATA;
        case (w)
            CMB_W_STD_ID: m = CMB_MASK_STD_ID;
            CMB_W_EXT_ID_HIGH: m = CMB_MASK_EXT_HIGH;
            CMB_W_EXT_ID_LOW_LEN: m = CMB_MASK_EXT_LOW;
            CMB_W_FILTER_HIT: m = CMB_MASK_FHIT;
            default: m = CMB_MASK_DATA;
        endcase
        return m;
    endfunction

    // Flat storage index of a word in a buffer.
    function automatic logic [IW-1:0] word_index(
        input logic [BW-1:0] b,
        input logic [CMB_WSEL_W-1:0] w
    );
        return IW'({b, w});
    endfunction

    // Number of bytes a length code carries; codes above eight mean eight.
    function automatic logic [3:0] byte_count(
        input logic [CMB_DLC_W-1:0] dlc
    );
        return (dlc > CMB_MAX_BYTES) ? CMB_MAX_BYTES : dlc;
    endfunction

    // ------------------------------------------------------------------
    // Storage and receive packing
    // ------------------------------------------------------------------
    // Buffer words live in plain flops with no reset: like the RAM they
    // stand for, their content is undefined until someone writes it.
    logic [CMB_WORD_W-1:0] mem_q [DEPTH];
    logic [CMB_WORD_W-1:0] mem_d [DEPTH];

    logic [CMB_WORDS*CMB_WORD_W-1:0] rx_words;
    logic [CMB_WORDS*2-1:0] rx_byte_we;
    wire logic rx_target_tx = buf_is_tx[rx_buf];
    wire logic mem_wr = mem_req && mem_we;
    wire logic mem_rd = mem_req && !mem_we;
    wire logic [IW-1:0] mem_idx = word_index(mem_buf, mem_word);
    wire logic [CMB_WORD_W-1:0] mem_wmask = word_mask(mem_word);

    cmb_rx_packer u_packer (
        .standard_identifier_bits(rx_sid),
        .srr(rx_srr),
        .ide(rx_ide),
        .extended_identifier_bits(rx_eid),
        .rtr(rx_rtr),
        .dlc(rx_dlc),
        .data(rx_data),
        .filter_num(rx_filter),
        .target_is_tx(rx_target_tx),
        .words(rx_words),
        .byte_we(rx_byte_we)
    );

    // Software and the engine may hit the same word in one cycle; the
    // engine's store wins so that a received message is never torn.
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
            if (mem_wr && (mem_idx == IW'(i))) begin
                // Unimplemented bits are dropped on the way in.
                mem_d[i] = mem_wdata & mem_wmask;
            end
            if (rx_store && (rx_buf == BW'(i / CMB_WORDS))) begin
                for (int k = 0; k < 2; k++) begin
                    if (rx_byte_we[(i % CMB_WORDS)*2 + k]) begin
                        mem_d[i][k*CMB_BYTE_W +: CMB_BYTE_W] =
                            rx_words[(i % CMB_WORDS)*CMB_WORD_W
                                     + k*CMB_BYTE_W +: CMB_BYTE_W];
                    end
                end
                mem_d[i] = mem_d[i]
                    & word_mask(CMB_WSEL_W'(i % CMB_WORDS));
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
        end
    end

    // ------------------------------------------------------------------
    // Memory read port
    // ------------------------------------------------------------------
    logic [CMB_WORD_W-1:0] mem_rdata_q;
    logic mem_rvalid_q;
    logic rx_done_q;

    // Reads mask again so a word never shows bits it does not implement.
    wire logic [CMB_WORD_W-1:0] mem_rword = mem_q[mem_idx] & mem_wmask;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_rdata_q <= CMB_RDATA_RST;
            mem_rvalid_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            mem_rvalid_q <= mem_rd;
            rx_done_q <= rx_store;
            if (mem_rd) begin
                mem_rdata_q <= mem_rword;
            end
        end
    end

    assign mem_rdata = mem_rdata_q;
    assign mem_rvalid = mem_rvalid_q;
    assign rx_done = rx_done_q;

    // ------------------------------------------------------------------
    // Transmit fetch
    // ------------------------------------------------------------------
    wire logic [CMB_WORD_W-1:0] tw0 = mem_q[word_index(tx_buf, CMB_W_STD_ID)];
    wire logic [CMB_WORD_W-1:0] tw1 =
        mem_q[word_index(tx_buf, CMB_W_EXT_ID_HIGH)];
    wire logic [CMB_WORD_W-1:0] tw2 =
        mem_q[word_index(tx_buf, CMB_W_EXT_ID_LOW_LEN)];
    wire logic [CMB_DLC_W-1:0] tx_dlc_w = tw2[CMB_DLC_LSB +: CMB_DLC_W];
    wire logic [3:0] tx_count = byte_count(tx_dlc_w);

    logic [CMB_DATA_BYTES*CMB_BYTE_W-1:0] tx_data_w;
    logic [CMB_DATA_BYTES-1:0] tx_be_w;

    always_comb begin
        tx_data_w = '0;
        tx_be_w = '0;
        for (int b = 0; b < CMB_DATA_BYTES; b++) begin
            // Bytes past the length code are not sent.
            tx_be_w[b] = (4'(b) < tx_count);
            if (tx_be_w[b]) begin
                // Even byte from the low half of its word.
                tx_data_w[b*CMB_BYTE_W +: CMB_BYTE_W] =
                    mem_q[word_index(tx_buf,
                        CMB_WSEL_W'(CMB_W_DATA_FIRST + 3'(b / 2)))]
                        [(b % 2)*CMB_BYTE_W +: CMB_BYTE_W];
            end
        end
    end

    logic tx_valid_q;
    logic [CMB_SID_W-1:0] tx_sid_q;
    logic tx_srr_q;
    logic tx_ide_q;
    logic [CMB_EID_W-1:0] tx_eid_q;
    logic tx_rtr_q;
    logic [CMB_DLC_W-1:0] tx_dlc_q;
    logic [CMB_DATA_BYTES*CMB_BYTE_W-1:0] tx_data_q;
    logic [CMB_DATA_BYTES-1:0] tx_be_q;

    // The reserved bits are not forwarded; the engine frames them as zero
    // and relies on software having written them that way.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_valid_q <= 1'b0;
            tx_sid_q <= '0;
            tx_srr_q <= 1'b0;
            tx_ide_q <= 1'b0;
            tx_eid_q <= '0;
            tx_rtr_q <= 1'b0;
            tx_dlc_q <= '0;
            tx_data_q <= '0;
            tx_be_q <= '0;
        end else begin
            tx_valid_q <= tx_fetch;
            if (tx_fetch) begin
                tx_sid_q <= tw0[CMB_SID_LSB +: CMB_SID_W];
                tx_srr_q <= tw0[CMB_SRR_BIT];
                tx_ide_q <= tw0[CMB_IDE_BIT];
                tx_eid_q <= {tw1[CMB_EID_HIGH_LSB +: CMB_EID_HIGH_W],
                    tw2[CMB_EID_LOW_LSB +: CMB_EID_LOW_W]};
                tx_rtr_q <= tw2[CMB_RTR_BIT];
                tx_dlc_q <= tx_dlc_w;
                tx_data_q <= tx_data_w;
                tx_be_q <= tx_be_w;
            end
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_sid = tx_sid_q;
    assign tx_srr = tx_srr_q;
    assign tx_ide = tx_ide_q;
    assign tx_eid = tx_eid_q;
    assign tx_rtr = tx_rtr_q;
    assign tx_dlc = tx_dlc_q;
    assign tx_data = tx_data_q;
    assign tx_byte_en = tx_be_q;
endmodule

// file: cmb_msg_buffer_assertions.sv
/*
 * Concurrent checks on the ports of the CAN message buffer store.
 * Assumes one clock, a synchronous active-low reset and one-cycle answers.
 */
`timescale 1ns/1ps
module cmb_msg_buffer_assertions
    import cmb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [CMB_WSEL_W-1:0] mem_word,
    input wire logic [CMB_WORD_W-1:0] mem_rdata,
    input wire logic mem_rvalid,
    // Engine side
    input wire logic rx_store,
    input wire logic rx_done,
    input wire logic tx_fetch,
    input wire logic tx_valid,
    input wire logic [CMB_DLC_W-1:0] tx_dlc,
    input wire logic [CMB_DATA_BYTES-1:0] tx_byte_en
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_read_answer: assert property (mem_req && !mem_we |=> mem_rvalid)
        else $error("read not answered in one cycle");
    a_no_stray_valid: assert property (!(mem_req && !mem_we) |=> !mem_rvalid)
        else $error("read valid without a read");
    a_rdata_hold: assert property (!mem_rvalid |-> $stable(mem_rdata))
        else $error("read data moved without a read");
    a_word0_unused: assert property (mem_rvalid && $past(mem_word) == 3'h0 |-> mem_rdata[15:13] == 3'h0)
        else $error("word 0 unused bits not zero");
    a_word1_unused: assert property (mem_rvalid && $past(mem_word) == 3'h1 |-> mem_rdata[15:12] == 4'h0)
        else $error("word 1 unused bits not zero");
    a_word2_unused: assert property (mem_rvalid && $past(mem_word) == 3'h2 |-> mem_rdata[7:5] == 3'h0)
        else $error("word 2 unused bits not zero");
    a_word7_unused: assert property (mem_rvalid && $past(mem_word) == 3'h7 |-> {mem_rdata[15:13], mem_rdata[7:0]} == 11'h000)
        else $error("word 7 unused bits not zero");
    a_store_done: assert property (rx_done == $past(rx_store))
        else $error("store completion not one cycle after store");
    a_fetch_valid: assert property (tx_fetch |=> tx_valid ##1 (tx_valid == $past(tx_fetch)))
        else $error("fetch not answered in one cycle");
    a_byte_lanes: assert property (tx_valid |-> tx_byte_en == (tx_dlc[3] ? 8'hff : 8'((16'h1 << tx_dlc) - 16'h1)))
        else $error("byte enables disagree with length code");
    a_fields_hold: assert property (!tx_fetch |=> $stable(tx_dlc) && $stable(tx_byte_en))
        else $error("fetched fields moved without a fetch");

    c_long_dlc: cover property (tx_valid && tx_dlc > 4'h8);
    c_word7_read: cover property (mem_rvalid && $past(mem_word) == 3'h7);
    c_back_store: cover property (rx_store ##1 rx_store);
endmodule

bind cmb_msg_buffer cmb_msg_buffer_assertions cmb_msg_buffer_assertions_i (
    .clk, .rstn, .mem_req, .mem_we, .mem_word, .mem_rdata, .mem_rvalid,
    .rx_store, .rx_done, .tx_fetch, .tx_valid, .tx_dlc, .tx_byte_en
);

// file: cmb_engine_model.sv
/*
 * Behavioural CAN protocol engine facing the buffer store.
 * Assumes its tasks are called from one process, one at a time.
 */
`timescale 1ns/1ps
module cmb_engine_model
    import cmb_pkg::*;
(
    // Clock
    input wire logic clk,
    // Receive store
    output logic rx_store,
    output logic [1:0] rx_buf,
    output logic [CMB_SID_W-1:0] rx_sid,
    output logic rx_srr,
    output logic rx_ide,
    output logic [CMB_EID_W-1:0] rx_eid,
    output logic rx_rtr,
    output logic [CMB_DLC_W-1:0] rx_dlc,
    output logic [63:0] rx_data,
    output logic [CMB_FHIT_W-1:0] rx_filter,
    // Transmit fetch
    output logic tx_fetch,
    output logic [1:0] tx_buf
);
    initial begin
        rx_store = 1'b0;
        tx_fetch = 1'b0;
        {rx_buf, rx_sid, rx_srr, rx_ide, rx_eid, rx_rtr} = '0;
        {rx_dlc, rx_data, rx_filter, tx_buf} = '0;
    end

    // A slow engine waits extra cycles; released data, extended id, length and filter lines show junk.
    task automatic store(input int gap, input logic [1:0] b,
        input logic [10:0] standard_identifier_bits, input logic srr, input logic ide,
        input logic [17:0] extended_identifier_bits, input logic rtr, input logic [3:0] dlc,
        input logic [63:0] d, input logic [4:0] f);
        repeat (gap + 1) @(posedge clk);
        #1;
        rx_buf = b;
        {rx_sid, rx_srr, rx_ide, rx_eid, rx_rtr} = {standard_identifier_bits, srr, ide, extended_identifier_bits, rtr};
        rx_dlc = dlc;
        rx_data = d;
        rx_filter = f;
        rx_store = 1'b1;
        @(posedge clk);
        #1;
        rx_store = 1'b0;
        rx_data = ~rx_data;
        rx_eid = ~rx_eid;
        rx_dlc = ~rx_dlc;
        rx_filter = ~rx_filter;
    endtask

    task automatic fetch(input logic [1:0] b);
        @(posedge clk);
        #1;
        tx_buf = b;
        tx_fetch = 1'b1;
        @(posedge clk);
        #1;
        tx_fetch = 1'b0;
        tx_buf = ~tx_buf;
    endtask
endmodule

// file: cmb_msg_buffer_tb_top.sv
/*
 * Self-checking testbench of the CAN message buffer store.
 * Assumes the engine model beside it and one-cycle answers on clk.
 */
`timescale 1ns/1ps
module cmb_msg_buffer_tb_top;
    import cmb_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mem_req = 1'b0;
    logic mem_we = 1'b0;
    logic [1:0] mem_buf = 2'h0;
    logic [2:0] mem_word = 3'h0;
    logic [15:0] mem_wdata = 16'h0000;
    logic [3:0] buf_is_tx = 4'h0;
    logic [15:0] mem_rdata;
    logic mem_rvalid, rx_store, rx_srr, rx_ide, rx_rtr, rx_done;
    logic tx_fetch, tx_valid, tx_srr, tx_ide, tx_rtr;
    logic [1:0] rx_buf, tx_buf;
    logic [10:0] rx_sid, tx_sid;
    logic [17:0] rx_eid, tx_eid;
    logic [3:0] rx_dlc, tx_dlc;
    logic [63:0] rx_data, tx_data;
    logic [4:0] rx_filter;
    logic [7:0] tx_byte_en;
    integer seed = 32'h9039d278;
    int num_errors = 0;
    int tests_run = 0;
    logic [15:0] em [4][8];

    always #2.5 clk = ~clk;

    cmb_msg_buffer #(.NUM_BUF(4)) cmb_msg_buffer_i (.clk, .rstn, .mem_req,
        .mem_we, .mem_buf, .mem_word, .mem_wdata, .mem_rdata, .mem_rvalid,
        .buf_is_tx, .rx_store, .rx_buf, .rx_sid, .rx_srr, .rx_ide, .rx_eid,
        .rx_rtr, .rx_dlc, .rx_data, .rx_filter, .rx_done, .tx_fetch, .tx_buf,
        .tx_valid, .tx_sid, .tx_srr, .tx_ide, .tx_eid, .tx_rtr, .tx_dlc,
        .tx_data, .tx_byte_en);
    cmb_engine_model cmb_engine_model_i (.clk, .rx_store, .rx_buf, .rx_sid,
        .rx_srr, .rx_ide, .rx_eid, .rx_rtr, .rx_dlc, .rx_data, .rx_filter,
        .tx_fetch, .tx_buf);

    // ------------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------------
    function automatic logic [15:0] wmask(input logic [2:0] w);
        case (w)
            3'h0: wmask = 16'h1fff;
            3'h1: wmask = 16'h0fff;
            3'h2: wmask = 16'hff1f;
            3'h7: wmask = 16'h1f00;
            default: wmask = 16'hffff;
        endcase
    endfunction

    function automatic logic [7:0] lanes(input logic [3:0] dlc);
        lanes = dlc[3] ? 8'hff : 8'((16'h1 << dlc) - 16'h1);
    endfunction

    task automatic chk16(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk64(input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic mem_acc(input logic we, input logic [1:0] b,
        input logic [2:0] w, input logic [15:0] d);
        @(posedge clk);
        #1;
        {mem_req, mem_we, mem_buf, mem_word, mem_wdata} = {1'b1, we, b, w, d};
        @(posedge clk);
        #1;
        mem_req = 1'b0;
        mem_wdata = ~mem_wdata;
        if (we) begin
            em[b][w] = d & wmask(w);
        end else begin
            chk16(16'h1, {15'h0, mem_rvalid});
            chk16(em[b][w], mem_rdata);
        end
    endtask

    task automatic do_store(input int n);
        logic [1:0] b;
        logic [2:0] fl;
        logic [3:0] dlc;
        logic [4:0] f;
        logic [7:0] m;
        logic [10:0] standard_identifier_bits;
        logic [17:0] extended_identifier_bits;
        logic [63:0] d, ed;
        b = 2'($random(seed));
        fl = 3'($random(seed));
        f = 5'($random(seed));
        standard_identifier_bits = 11'($random(seed));
        extended_identifier_bits = 18'($random(seed));
        d = {$random(seed), $random(seed)};
        dlc = (n < 4) ? 4'(16'h18f0 >> (4 * n)) : 4'($random(seed));
        m = lanes(dlc);
        buf_is_tx = 4'($random(seed));
        cmb_engine_model_i.store(n % 3, b, standard_identifier_bits, fl[0], fl[1], extended_identifier_bits, fl[2], dlc, d, f);
        chk16(16'h1, {15'h0, rx_done});
        em[b][0] = {3'h0, standard_identifier_bits, fl[0], fl[1]};
        em[b][1] = {4'h0, extended_identifier_bits[17:6]};
        em[b][2] = {extended_identifier_bits[5:0], fl[2], 5'h00, dlc};
        for (int k = 0; k < 8; k++) begin
            if (m[k]) em[b][3 + k / 2][8 * (k % 2) +: 8] = d[8 * k +: 8];
        end
        if (!buf_is_tx[b]) em[b][7] = {3'h0, f, 8'h00};
        for (int w = 0; w < 8; w++) begin
            mem_acc(1'b0, b, 3'(w), 16'h0000);
        end
        cmb_engine_model_i.fetch(b);
        for (int k = 0; k < 8; k++) begin
            ed[8 * k +: 8] = m[k] ? em[b][3 + k / 2][8 * (k % 2) +: 8] : 8'h00;
        end
        chk16(16'h1, {15'h0, tx_valid});
        chk64(64'({em[b][0][12:0], em[b][1][11:0], em[b][2][15:9], em[b][2][3:0]}),
            64'({tx_sid, tx_srr, tx_ide, tx_eid, tx_rtr, tx_dlc}));
        chk64(64'(m), 64'(tx_byte_en));
        chk64(ed, tx_data);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 32; i++) begin
            mem_acc(1'b1, 2'(i / 8), 3'(i % 8), 16'($random(seed)) & ((i % 8 == 2) ? 16'hfeef : 16'hffff));
        end
        for (int i = 0; i < 32; i++) begin
            mem_acc(1'b0, 2'(i / 8), 3'(i % 8), 16'h0000);
        end
        for (int n = 0; n < 24; n++) begin
            do_store(n);
        end
        stop_test();
    end

    // Cuts a hang short well after the normal end of the run.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule
